// ===== rtl/rail_delay_seq.sv
// Startup and shutdown delay sequencer for one step-down rail
module rail_delay_seq #(
  parameter int HALF_MS_CYCLES = regulator_seq_pkg::HALF_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Enable pin edges, one-cycle pulses
  input wire logic pin_rise,
  input wire logic pin_fall,
  // Delay configuration
  input wire regulator_seq_pkg::rail_delay_cfg_s cfg,
  // Rail switch
  output logic rail_on
);
  import regulator_seq_pkg::*;

  localparam int PRE_W = (HALF_MS_CYCLES > 1) ? $clog2(HALF_MS_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HALF_MS_CYCLES - 1);

  // Refuse a tick period the prescaler cannot count
  if (HALF_MS_CYCLES < 1) begin : g_bad_period
    $error("HALF_MS_CYCLES must be at least 1");
  end

  typedef enum logic [1:0] {RAIL_OFF, WAIT_ON, RAIL_ON, WAIT_OFF} rail_st_e;

  rail_st_e state_ff, nxt_state; // Sequencer state
  logic [PRE_W-1:0] pre_ff, nxt_pre; // Cycles into current half-ms unit
  logic [4:0] units_ff, nxt_units; // Half-ms units still to wait
  logic rail_on_ff, nxt_rail_on; // Registered switch

  // Next state: each edge restarts the count and drops the opposite wait
  always_comb begin
    nxt_state = state_ff;
    nxt_pre = pre_ff;
    nxt_units = units_ff;
    if (pin_rise) begin
      // Scale select doubles the unit to 1 ms
      nxt_pre = '0;
      nxt_units = {1'b0, cfg.on_code} << cfg.on_scale;
      nxt_state = (cfg.on_code == 4'h0) ? RAIL_ON : WAIT_ON;
    end else if (pin_fall) begin
      nxt_pre = '0;
      nxt_units = {1'b0, cfg.off_code} << cfg.off_scale;
      // Code zero switches off at once
      nxt_state = (cfg.off_code == 4'h0) ? RAIL_OFF : WAIT_OFF;
    end else begin
      case (state_ff)
        WAIT_ON, WAIT_OFF: begin
          // Half-ms tick derived from the system clock
          if (pre_ff == PRE_LAST) begin
            nxt_pre = '0;
            if (units_ff <= 5'h01) begin
              nxt_state = (state_ff == WAIT_ON) ? RAIL_ON : RAIL_OFF;
              nxt_units = 5'h00;
            end else begin
              nxt_units = units_ff - 5'h01;
            end
          end else begin
            nxt_pre = pre_ff + PRE_W'(1);
          end
        end
        default: begin
          // Settled states hold
          nxt_pre = '0;
        end
      endcase
    end
    // Waits keep the present level, so a cancelled wait never glitches
    nxt_rail_on = (nxt_state == RAIL_ON) ||
      ((nxt_state != RAIL_OFF) && rail_on_ff);
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= RAIL_OFF;
      pre_ff <= '0;
      units_ff <= 5'h00;
      rail_on_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pre_ff <= nxt_pre;
      units_ff <= nxt_units;
      rail_on_ff <= nxt_rail_on;
    end
  end

  assign rail_on = rail_on_ff;

endmodule // rail_delay_seq

// ===== rtl/regulator_enable_seq_regs.sv
// Register file and enable sequencing for two linear and two step-down rails
//
// What this block does
// - Linear A discharges when off, if enabled
// - Linear B discharges when off, if enabled
// - Linear A: enable bit, optionally ANDed with pin
// - Linear B: enable bit, optionally ANDed with pin
// - Linear A code: 0.8 V plus 100 mV steps
// - Step-down A turns off after coded delay
// - Step-down A turns on after coded delay
// - Step-down B off delay from upper nibble
// - Step-down B on delay, lower nibble, reset 4
module regulator_enable_seq_regs #(
  parameter int HALF_MS_CYCLES = regulator_seq_pkg::HALF_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access port
  input wire regulator_seq_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Enable pin and delay scale selects
  input wire logic en_pin,
  input wire logic startup_scale_sel,
  input wire logic shutdown_scale_sel,
  // Linear regulator A controls
  output logic linreg_a_run,
  output logic linreg_a_discharge_on,
  output logic [4:0] linreg_a_volt_code,
  // Linear regulator B controls
  output logic linreg_b_run,
  output logic linreg_b_discharge_on,
  output logic [4:0] linreg_b_volt_code,
  // Step-down converter switches
  output logic stepdown_a_run,
  output logic stepdown_b_run
);
  import regulator_seq_pkg::*;

  // Refuse a tick period that cannot be counted
  if (HALF_MS_CYCLES < 1) begin : g_bad_period
    $error("HALF_MS_CYCLES must be at least 1");
  end

  // Register storage; reserved bits are kept as written
  logic [7:0] linreg_a_control_ff, nxt_linreg_a_control;
  logic [7:0] linreg_b_control_ff, nxt_linreg_b_control;
  logic [7:0] linreg_a_voltage_ff, nxt_linreg_a_voltage;
  logic [7:0] linreg_b_voltage_ff, nxt_linreg_b_voltage;
  logic [7:0] stepdown_a_delays_ff, nxt_stepdown_a_delays;
  logic [7:0] stepdown_b_delays_ff, nxt_stepdown_b_delays;
  logic [7:0] rdata_ff, nxt_rdata; // Read answer holding register

  // Pin edge detection
  logic en_prev_ff, nxt_en_prev; // Pin level one cycle ago
  logic pin_rise; // Enable pin rose this cycle
  logic pin_fall; // Enable pin fell this cycle

  // Linear regulator output registers
  logic linreg_a_run_ff, nxt_linreg_a_run;
  logic linreg_b_run_ff, nxt_linreg_b_run;
  logic linreg_a_dis_ff, nxt_linreg_a_dis;
  logic linreg_b_dis_ff, nxt_linreg_b_dis;

  // Step-down sequencer wiring
  rail_delay_cfg_s stepdown_cfg [2]; // Delay set of each converter
  logic [1:0] stepdown_run; // Switch from each sequencer

  // Register writes; a read in the same cycle returns the old value
  always_comb begin
    nxt_linreg_a_control = linreg_a_control_ff;
    nxt_linreg_b_control = linreg_b_control_ff;
    nxt_linreg_a_voltage = linreg_a_voltage_ff;
    nxt_linreg_b_voltage = linreg_b_voltage_ff;
    nxt_stepdown_a_delays = stepdown_a_delays_ff;
    nxt_stepdown_b_delays = stepdown_b_delays_ff;
    if (reg_req.wr) begin
      case (reg_req.addr)
        LINREG_A_CONTROL_OFS: nxt_linreg_a_control = reg_req.wdata;
        LINREG_B_CONTROL_OFS: nxt_linreg_b_control = reg_req.wdata;
        // Reserved codes are stored as written; software must avoid them
        LINREG_A_VOLTAGE_OFS: nxt_linreg_a_voltage = reg_req.wdata;
        LINREG_B_VOLTAGE_OFS: nxt_linreg_b_voltage = reg_req.wdata;
        STEPDOWN_A_DELAYS_OFS: nxt_stepdown_a_delays = reg_req.wdata;
        STEPDOWN_B_DELAYS_OFS: nxt_stepdown_b_delays = reg_req.wdata;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read answer, registered one cycle after the request
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_req.rd) begin
      case (reg_req.addr)
        LINREG_A_CONTROL_OFS: nxt_rdata = linreg_a_control_ff;
        LINREG_B_CONTROL_OFS: nxt_rdata = linreg_b_control_ff;
        LINREG_A_VOLTAGE_OFS: nxt_rdata = linreg_a_voltage_ff;
        LINREG_B_VOLTAGE_OFS: nxt_rdata = linreg_b_voltage_ff;
        STEPDOWN_A_DELAYS_OFS: nxt_rdata = stepdown_a_delays_ff;
        STEPDOWN_B_DELAYS_OFS: nxt_rdata = stepdown_b_delays_ff;
        default: nxt_rdata = UNMAPPED_READ_VAL;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linreg_a_control_ff <= LINREG_A_CONTROL_RST;
      linreg_b_control_ff <= LINREG_B_CONTROL_RST;
      linreg_a_voltage_ff <= LINREG_A_VOLTAGE_RST;
      linreg_b_voltage_ff <= LINREG_B_VOLTAGE_RST;
      stepdown_a_delays_ff <= STEPDOWN_A_DELAYS_RST;
      stepdown_b_delays_ff <= STEPDOWN_B_DELAYS_RST;
      rdata_ff <= 8'h00;
    end else begin
      linreg_a_control_ff <= nxt_linreg_a_control;
      linreg_b_control_ff <= nxt_linreg_b_control;
      linreg_a_voltage_ff <= nxt_linreg_a_voltage;
      linreg_b_voltage_ff <= nxt_linreg_b_voltage;
      stepdown_a_delays_ff <= nxt_stepdown_a_delays;
      stepdown_b_delays_ff <= nxt_stepdown_b_delays;
      rdata_ff <= nxt_rdata;
    end
  end

  // Edge detection on the enable pin
  always_comb begin
    nxt_en_prev = en_pin;
    pin_rise = en_pin & ~en_prev_ff;
    pin_fall = ~en_pin & en_prev_ff;
  end

  // Pin history starts low, so a pin high at reset counts as a rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_prev_ff <= 1'b0;
    end else begin
      en_prev_ff <= nxt_en_prev;
    end
  end

  // Linear rails follow the pin directly, with no sequencing delay
  always_comb begin
    nxt_linreg_a_run = linreg_a_control_ff[CTRL_ON_BIT] &
      (~linreg_a_control_ff[CTRL_PIN_GATE_BIT] | en_pin);
    nxt_linreg_b_run = linreg_b_control_ff[CTRL_ON_BIT] &
      (~linreg_b_control_ff[CTRL_PIN_GATE_BIT] | en_pin);
    // Discharge only while the rail is off, so both never overlap
    nxt_linreg_a_dis = linreg_a_control_ff[CTRL_DISCHARGE_BIT] &
      ~nxt_linreg_a_run;
    nxt_linreg_b_dis = linreg_b_control_ff[CTRL_DISCHARGE_BIT] &
      ~nxt_linreg_b_run;
  end

  // Linear rail output flops; rails start off with discharge off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linreg_a_run_ff <= 1'b0;
      linreg_b_run_ff <= 1'b0;
      linreg_a_dis_ff <= 1'b0;
      linreg_b_dis_ff <= 1'b0;
    end else begin
      linreg_a_run_ff <= nxt_linreg_a_run;
      linreg_b_run_ff <= nxt_linreg_b_run;
      linreg_a_dis_ff <= nxt_linreg_a_dis;
      linreg_b_dis_ff <= nxt_linreg_b_dis;
    end
  end

  // Delay sets: upper nibble for shutdown, lower nibble for startup
  always_comb begin
    stepdown_cfg[0].on_code =
      stepdown_a_delays_ff[ON_DELAY_LSB +: DELAY_CODE_W];
    stepdown_cfg[0].off_code =
      stepdown_a_delays_ff[OFF_DELAY_LSB +: DELAY_CODE_W];
    stepdown_cfg[1].on_code =
      stepdown_b_delays_ff[ON_DELAY_LSB +: DELAY_CODE_W];
    stepdown_cfg[1].off_code =
      stepdown_b_delays_ff[OFF_DELAY_LSB +: DELAY_CODE_W];
    stepdown_cfg[0].on_scale = startup_scale_sel;
    stepdown_cfg[1].on_scale = startup_scale_sel;
    stepdown_cfg[0].off_scale = shutdown_scale_sel;
    stepdown_cfg[1].off_scale = shutdown_scale_sel;
  end

  // One sequencer per step-down converter
  for (genvar i = 0; i < 2; i++) begin : g_stepdown
    rail_delay_seq #(
      .HALF_MS_CYCLES(HALF_MS_CYCLES)
    ) u_seq (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall),
      .cfg(stepdown_cfg[i]),
      .rail_on(stepdown_run[i])
    );
  end

  // Outputs; voltage codes pass straight from their registers
  assign reg_rdata = rdata_ff;
  assign linreg_a_run = linreg_a_run_ff;
  assign linreg_b_run = linreg_b_run_ff;
  assign linreg_a_discharge_on = linreg_a_dis_ff;
  assign linreg_b_discharge_on = linreg_b_dis_ff;
  assign linreg_a_volt_code =
    linreg_a_voltage_ff[VOLT_CODE_LSB +: VOLT_CODE_W];
  assign linreg_b_volt_code =
    linreg_b_voltage_ff[VOLT_CODE_LSB +: VOLT_CODE_W];
  assign stepdown_a_run = stepdown_run[0];
  assign stepdown_b_run = stepdown_run[1];

endmodule // regulator_enable_seq_regs

// ===== rtl/regulator_seq_pkg.sv
// Shared constants, register map and carrier types for the regulator block
package regulator_seq_pkg;

  // Register byte offsets
  localparam logic [7:0] LINREG_A_CONTROL_OFS = 8'h08;
  localparam logic [7:0] LINREG_B_CONTROL_OFS = 8'h09;
  localparam logic [7:0] LINREG_A_VOLTAGE_OFS = 8'h0A;
  localparam logic [7:0] LINREG_B_VOLTAGE_OFS = 8'h0B;
  localparam logic [7:0] STEPDOWN_A_DELAYS_OFS = 8'h0C;
  localparam logic [7:0] STEPDOWN_B_DELAYS_OFS = 8'h0D;

  // Values after reset
  localparam logic [7:0] LINREG_A_CONTROL_RST = 8'h07;
  localparam logic [7:0] LINREG_B_CONTROL_RST = 8'h07;
  localparam logic [7:0] LINREG_A_VOLTAGE_RST = 8'h19;
  localparam logic [7:0] LINREG_B_VOLTAGE_RST = 8'h19;
  localparam logic [7:0] STEPDOWN_A_DELAYS_RST = 8'h23;
  localparam logic [7:0] STEPDOWN_B_DELAYS_RST = 8'h24;
  localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

  // Control register field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_PIN_GATE_BIT = 1;
  localparam int CTRL_DISCHARGE_BIT = 2;

  // Field positions of voltage and delay registers
  localparam int VOLT_CODE_LSB = 0;
  localparam int VOLT_CODE_W = 5;
  localparam int ON_DELAY_LSB = 0;
  localparam int OFF_DELAY_LSB = 4;
  localparam int DELAY_CODE_W = 4;

  // Delay unit timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Delay configuration of one step-down rail
  typedef struct packed {
    logic [3:0] on_code;
    logic [3:0] off_code;
    logic on_scale;
    logic off_scale;
  } rail_delay_cfg_s;

endpackage : regulator_seq_pkg

// ===== sim/regulator_enable_seq_regs_asserts.sv
// Port-level checker for the regulator register and sequencing block
module regulator_enable_seq_regs_asserts
  import regulator_seq_pkg::*;
#(
  parameter int HALF_MS_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire regulator_seq_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  // Pin and scale selects
  input wire logic en_pin,
  input wire logic startup_scale_sel,
  input wire logic shutdown_scale_sel,
  // Rail outputs
  input wire logic linreg_a_run,
  input wire logic linreg_a_discharge_on,
  input wire logic [4:0] linreg_a_volt_code,
  input wire logic linreg_b_run,
  input wire logic linreg_b_discharge_on,
  input wire logic [4:0] linreg_b_volt_code,
  input wire logic stepdown_a_run,
  input wire logic stepdown_b_run
);
  logic [7:0] sh_ff [6]; // Mirror of the six registers
  logic [7:0] nxt_sh [6];
  logic [7:0] rd_exp; // What a read of the current address returns
  logic [7:0] ca, cb, va; // Mirrored control A, control B, voltage A
  assign ca = sh_ff[0];
  assign cb = sh_ff[1];
  assign va = sh_ff[2];
  // Mirror follows writes; unmapped places read as zero
  always_comb begin
    nxt_sh = sh_ff;
    rd_exp = UNMAPPED_READ_VAL;
    if (reg_req.addr inside {[8'h08:8'h0D]}) begin
      rd_exp = sh_ff[3'(reg_req.addr - 8'h08)];
      if (reg_req.wr) nxt_sh[3'(reg_req.addr - 8'h08)] = reg_req.wdata;
    end
  end
  // Mirror registers, loaded with reset values
  always_ff @(posedge clk) begin
    if (sys_rst) sh_ff <= '{LINREG_A_CONTROL_RST, LINREG_B_CONTROL_RST,
      LINREG_A_VOLTAGE_RST, LINREG_B_VOLTAGE_RST,
      STEPDOWN_A_DELAYS_RST, STEPDOWN_B_DELAYS_RST};
    else sh_ff <= nxt_sh;
  end
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Outputs are forced low at the first edge after reset, hence the guard
  property p_lina_run;
    !$past(sys_rst) |-> linreg_a_run ==
      ($past(ca[0]) & (!$past(ca[1]) | $past(en_pin)));
  endproperty
  a_lina_run: assert property (p_lina_run)
    else $error("linear A run wrong");
  property p_linb_run;
    !$past(sys_rst) |-> linreg_b_run ==
      ($past(cb[0]) & (!$past(cb[1]) | $past(en_pin)));
  endproperty
  a_linb_run: assert property (p_linb_run)
    else $error("linear B run wrong");
  property p_lina_dis;
    !$past(sys_rst) |-> linreg_a_discharge_on == ($past(ca[2]) & !linreg_a_run);
  endproperty
  a_lina_dis: assert property (p_lina_dis)
    else $error("linear A discharge wrong");
  property p_linb_dis;
    !$past(sys_rst) |-> linreg_b_discharge_on == ($past(cb[2]) & !linreg_b_run);
  endproperty
  a_linb_dis: assert property (p_linb_dis)
    else $error("linear B discharge wrong");
  property p_volt_a;
    $stable(va) |-> linreg_a_volt_code == va[4:0];
  endproperty
  a_volt_a: assert property (p_volt_a)
    else $error("linear A code wrong");
  property p_rdata;
    reg_req.rd |=> reg_rdata == $past(rd_exp);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data wrong");
  // A converter only switches in the direction the pin last asked for
  property p_sda_on;
    $rose(stepdown_a_run) |-> $past(en_pin);
  endproperty
  a_sda_on: assert property (p_sda_on)
    else $error("step-down A rose with pin low");
  property p_sdb_off;
    $fell(stepdown_b_run) |-> !$past(en_pin);
  endproperty
  a_sdb_off: assert property (p_sdb_off)
    else $error("step-down B fell with pin high");
endmodule // regulator_enable_seq_regs_asserts

// ===== sim/tb_regulator_enable_seq_regs.sv
// Self-checking bench for the regulator register and sequencing block
module tb_regulator_enable_seq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import regulator_seq_pkg::*;
  localparam int H = 4; // Short half-millisecond keeps the run brief
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic en_pin = 1'b0;
  logic startup_scale_sel = 1'b0;
  logic shutdown_scale_sel = 1'b0;
  reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic linreg_a_run, linreg_a_discharge_on, linreg_b_run;
  logic linreg_b_discharge_on, stepdown_a_run, stepdown_b_run;
  logic [4:0] linreg_a_volt_code, linreg_b_volt_code;
  logic [7:0] exp_q [$]; // Expected read answers, oldest first
  logic [7:0] v [6]; // Values written in the random pass
  logic taken = 1'b0;
  logic hi;
  logic [2:0] c;
  logic er, ed;
  int num_errors = 0;
  int total_checks = 0;
  regulator_enable_seq_regs #(.HALF_MS_CYCLES(H)) uut (.clk, .sys_rst,
    .reg_req, .reg_rdata, .en_pin, .startup_scale_sel, .shutdown_scale_sel,
    .linreg_a_run, .linreg_a_discharge_on, .linreg_a_volt_code,
    .linreg_b_run, .linreg_b_discharge_on, .linreg_b_volt_code,
    .stepdown_a_run, .stepdown_b_run);
  always #10 clk = ~clk;
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One register request, issued at a clock edge; reads note their answer
  task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d,
    logic [7:0] e);
    @(posedge clk);
    reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
    if (r) exp_q.push_back(e);
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(posedge clk);
      reg_req <= '0;
    end
  endtask
  // Moves the pin and counts edges until each converter follows it
  task automatic edge_time(logic lvl, int ea, int eb);
    int na, nb;
    na = 0;
    nb = 0;
    @(posedge clk);
    en_pin <= lvl;
    for (int n = 1; n <= 200; n++) begin
      @(posedge clk);
      #1;
      if (na == 0 && stepdown_a_run === lvl) na = n;
      if (nb == 0 && stepdown_b_run === lvl) nb = n;
    end
    chk("stepdown_a delay", 8'(ea), 8'(na));
    chk("stepdown_b delay", 8'(eb), 8'(nb));
  endtask
  // Answer stands from the edge that took the read until the next read
  always @(posedge clk) begin
    taken = reg_req.rd & ~sys_rst;
    #1;
    if (taken) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog: the sequence needs about 1100 cycles
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hCEA5));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then a read of an unmapped place
    acc(0, 1, LINREG_A_CONTROL_OFS, 0, LINREG_A_CONTROL_RST);
    acc(0, 1, LINREG_B_CONTROL_OFS, 0, LINREG_B_CONTROL_RST);
    acc(0, 1, LINREG_A_VOLTAGE_OFS, 0, 8'h19);
    acc(0, 1, LINREG_B_VOLTAGE_OFS, 0, 8'h19);
    acc(0, 1, STEPDOWN_A_DELAYS_OFS, 0, 8'h23);
    acc(0, 1, STEPDOWN_B_DELAYS_OFS, 0, 8'h24);
    acc(0, 1, 8'h0E, 0, 8'h00);
    idle(2);
    // Reset delay codes at the short unit: code N takes N*H+1 counted edges
    edge_time(1'b1, 3 * H + 1, 4 * H + 1);
    edge_time(1'b0, 2 * H + 1, 2 * H + 1);
    // Extreme codes with both units doubled
    acc(1, 0, STEPDOWN_A_DELAYS_OFS, 8'hF0, 0);
    acc(1, 0, STEPDOWN_B_DELAYS_OFS, 8'h1F, 0);
    startup_scale_sel <= 1'b1;
    shutdown_scale_sel <= 1'b1;
    idle(1);
    // Code zero follows the pin one edge later, whatever the scale
    edge_time(1'b1, 1, 30 * H + 1);
    edge_time(1'b0, 30 * H + 1, 2 * H + 1);
    // A short pin pulse cancels pending startups: rails must stay off
    acc(1, 0, STEPDOWN_A_DELAYS_OFS, 8'h33, 0);
    idle(1);
    en_pin <= 1'b1;
    idle(3);
    en_pin <= 1'b0;
    hi = 1'b0;
    repeat (150) begin
      @(posedge clk);
      hi = hi | stepdown_a_run | stepdown_b_run;
    end
    chk("cancelled rails", 8'h00, 8'(hi));
    // Random back-to-back writes and read-back; legal voltage codes only
    for (int i = 0; i < 6; i++) begin
      v[i] = 8'($urandom);
      if (i == 2 || i == 3) v[i] = {3'($urandom), 5'($urandom_range(25))};
      acc(1, 0, 8'h08 + 8'(i), v[i], 0);
    end
    for (int i = 0; i < 6; i++) acc(0, 1, 8'h08 + 8'(i), 0, v[i]);
    acc(1, 0, 8'h20, 8'hFF, 0);
    acc(0, 1, 8'h20, 0, 8'h00);
    // Read and write together return the old value first
    acc(1, 1, LINREG_A_VOLTAGE_OFS, 8'h05, v[2]);
    acc(0, 1, LINREG_A_VOLTAGE_OFS, 0, 8'h05);
    idle(3);
    #1;
    chk("linreg_a_volt_code", 8'h05, 8'(linreg_a_volt_code));
    chk("linreg_b_volt_code", {3'b0, v[3][4:0]}, 8'(linreg_b_volt_code));
    // Every control setting against both pin levels
    for (int k = 0; k < 16; k++) begin
      c = 3'(k);
      acc(1, 0, LINREG_A_CONTROL_OFS, {5'b0, c}, 0);
      acc(1, 0, LINREG_B_CONTROL_OFS, {5'b0, c ^ 3'b101}, 0);
      en_pin <= k[3];
      idle(3);
      #1;
      er = c[0] & (~c[1] | k[3]);
      ed = c[2] & ~er;
      chk("linreg a", {6'b0, er, ed}, {6'b0, linreg_a_run,
        linreg_a_discharge_on});
      // Control B holds c with bits 0 and 2 inverted
      er = ~c[0] & (~c[1] | k[3]);
      ed = ~c[2] & ~er;
      chk("linreg b", {6'b0, er, ed}, {6'b0, linreg_b_run,
        linreg_b_discharge_on});
    end
    print_verdict();
  end
endmodule // tb_regulator_enable_seq_regs

bind regulator_enable_seq_regs regulator_enable_seq_regs_asserts #(
  .HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (.clk, .sys_rst, .reg_req,
  .reg_rdata, .en_pin, .startup_scale_sel, .shutdown_scale_sel,
  .linreg_a_run, .linreg_a_discharge_on, .linreg_a_volt_code,
  .linreg_b_run, .linreg_b_discharge_on, .linreg_b_volt_code,
  .stepdown_a_run, .stepdown_b_run);
